//--- inc/pepwm_pkg.sv
// shared constants, register map and carriers of the power and energy monitor
package pepwm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int SMP_W = 12;
    localparam int PWR_W = 24;
    localparam int STD_W = 16;
    localparam int LIM_W = 16;
    localparam int ROLL_W = 16;
    localparam int CNT_W = 24;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int WARN_N = 7;
    ////////////////////////////////////////////////////////////////////////////
    // reset values and scale ends
    localparam logic [PWR_W-1:0] PWR_POS_MAX = 24'h7F_FFFF;
    localparam logic [LIM_W-1:0] LIM_OVER_RST = 16'h7FFF;
    localparam logic [LIM_W-1:0] LIM_UNDER_RST = 16'h0000;
    localparam logic [1:0] CTRL_RST = 2'h3;
    ////////////////////////////////////////////////////////////////////////////
    // register word indices
    localparam logic [ADDR_W-1:0] A_PWR_STD = 6'h00;
    localparam logic [ADDR_W-1:0] A_PWR_WIDE = 6'h01;
    localparam logic [ADDR_W-1:0] A_EN_SHORT0 = 6'h02;
    localparam logic [ADDR_W-1:0] A_EN_SHORT1 = 6'h03;
    localparam logic [ADDR_W-1:0] A_EN_WIDE0 = 6'h04;
    localparam logic [ADDR_W-1:0] A_EN_WIDE1 = 6'h05;
    localparam logic [ADDR_W-1:0] A_EN_WIDE2 = 6'h06;
    localparam logic [ADDR_W-1:0] A_CUR = 6'h08;
    localparam logic [ADDR_W-1:0] A_VIN = 6'h09;
    localparam logic [ADDR_W-1:0] A_VOUT = 6'h0A;
    localparam logic [ADDR_W-1:0] A_TEMP = 6'h0B;
    localparam logic [ADDR_W-1:0] A_PK_CUR = 6'h10;
    localparam logic [ADDR_W-1:0] A_PK_VIN = 6'h11;
    localparam logic [ADDR_W-1:0] A_PK_VOUT = 6'h12;
    localparam logic [ADDR_W-1:0] A_PK_PWR = 6'h13;
    localparam logic [ADDR_W-1:0] A_PK_TEMP = 6'h14;
    localparam logic [ADDR_W-1:0] A_LIM_BASE = 6'h18;
    localparam logic [ADDR_W-1:0] A_WARN = 6'h20;
    localparam logic [ADDR_W-1:0] A_CLR_FLT = 6'h21;
    localparam logic [ADDR_W-1:0] A_CTRL = 6'h22;

    ////////////////////////////////////////////////////////////////////////////
    // limit, warning and control bit order (limit index = A_LIM_BASE + bit)
    localparam int W_VIN_OV = 0;
    localparam int W_VIN_UV = 1;
    localparam int W_VOUT_OV = 2;
    localparam int W_VOUT_UV = 3;
    localparam int W_OC = 4;
    localparam int W_OT = 5;
    localparam int W_OP = 6;
    localparam int C_OUT_ON = 0;
    localparam int C_MON_EN = 1;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [SMP_W-1:0] iout;
        logic [SMP_W-1:0] vin;
        logic [SMP_W-1:0] vout;
        logic [SMP_W-1:0] temp;
    } pepwm_sample_t;

    typedef struct packed {
        logic [PWR_W-1:0] acc;
        logic [ROLL_W-1:0] roll;
        logic [CNT_W-1:0] cnt;
    } pepwm_energy_t;

endpackage

//--- rtl/pepwm_peak.sv
// one peak holder: keeps the largest averaged value since its last clear
`timescale 1ns/1ps
`default_nettype none
module pepwm_peak #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // update and clear
    input wire logic upd,
    input wire logic [W-1:0] val,
    input wire logic clr,
    // held peak
    output logic [W-1:0] peak
);
    logic [W-1:0] peak_q;
    logic [W-1:0] peak_d;

    always_comb begin
        peak_d = peak_q;
        if (clr) begin
            peak_d = '0;
        end
        // any sample in the clearing cycle still lands, larger or not
        if (upd && (val > peak_q || clr)) begin
            peak_d = val;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            peak_q <= '0;
        end else begin
            peak_q <= peak_d;
        end
    end

    assign peak = peak_q;
endmodule
`default_nettype wire

//--- rtl/pepwm_limit_cmp.sv
// one strict threshold comparison on a fresh value
`timescale 1ns/1ps
`default_nettype none
module pepwm_limit_cmp #(
    parameter int W = 12,
    parameter bit OVER = 1'b1
) (
    // fresh value
    input wire logic valid,
    input wire logic [W-1:0] val,
    // signed two-byte limit
    input wire logic [15:0] limit,
    // limit crossed
    output logic hit
);
    logic signed [16:0] v_s;
    logic signed [16:0] l_s;

    always_comb begin
        v_s = $signed({1'b0, 16'(val)});
        l_s = $signed({limit[15], limit});
        // equality never fires
        if (OVER) begin
            hit = valid && (v_s > l_s);
        end else begin
            hit = valid && (v_s < l_s);
        end
    end
endmodule
`default_nettype wire

//--- rtl/pepwm_monitor.sv
// power, energy, peak and warning back end of the power monitor
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: power is the unsigned 12 by 12 product of voltage and current codes.
// R2: current codes at or below the zero code count as zero current.
// R3: wide power readback gives all 24 bits, top bit always zero.
// R4: standard power readback gives upper 16 of 24 bits, top bit zero.
// R5: each power value adds into a 24-bit accumulator whose top bit stays zero.
// R6: accumulator wrap past its positive maximum bumps a 16-bit rollover counter.
// R7: rollover counter is plain binary and wraps to zero after all ones.
// R8: a 24-bit sample counter counts every accumulated power value.
// R9: host times its own reads and derives average power from deltas.
// R10: host reads energy before the rollover counter wraps twice.
// R11: short energy read gives acc upper 16, rollover low 8, all sample bits.
// R12: wide energy read gives all accumulator, rollover and sample counter bits.
// R13: separate peaks for current, input voltage, output voltage, power, temperature.
// R14: peaks only take averaged samples, never raw intermediate values.
// R15: writing zero to a peak clears that peak only.
// R16: warnings need strictly above an over limit or strictly below an under limit.
// R17: under limits reset to minimum, over limits to maximum scale.
// R18: compare vin over/under, vout over/under, current, temperature and power.
// R19: values exchanged are two-byte two's complement integers.
// R20: host divides wide power and energy by 256 before scaling.
// R21: warning bits stay latched until clear-faults or output off then on.
// R22: energy, rollover and sample counts are captured together when a read starts.
// R23: a peak loads a new value only when it is larger; the code also loads any sample that lands in the clearing cycle, larger or not.
module pepwm_monitor
    import pepwm_pkg::*;
#(
    parameter logic [SMP_W-1:0] CUR_ZERO_CODE = 12'h000,
    parameter int AW = ADDR_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // averaged samples from the monitor front end
    input wire logic smp_valid,
    input wire pepwm_sample_t smp,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // status
    output logic [WARN_N-1:0] warn_status,
    output logic [PWR_W-1:0] power_wide_value
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (AW < ADDR_W || AW > 16) begin : g_bad_aw
        $error("address width must be 6 to 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // latest averaged samples
    pepwm_sample_t last_q;
    pepwm_sample_t last_d;
    logic smp_take;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;

    // samples are dropped while the monitor is disabled
    assign smp_take = smp_valid && ctrl_q[C_MON_EN];

    always_comb begin
        last_d = last_q;
        if (smp_take) begin
            last_d = smp;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_q <= '0;
        end else begin
            last_q <= last_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power product and energy accumulation
    logic [SMP_W-1:0] cur_pos;
    logic [PWR_W-1:0] prod;
    logic [PWR_W-1:0] pwr_q;
    logic [PWR_W-1:0] pwr_d;
    logic pwr_vld_q;
    logic pwr_vld_d;
    pepwm_energy_t en_q;
    pepwm_energy_t en_d;
    logic [PWR_W-1:0] sum;

    always_comb begin
        cur_pos = (smp.iout > CUR_ZERO_CODE) ? smp.iout : '0; // R2
        prod = PWR_W'({12'h000, smp.vin}) * PWR_W'({12'h000, cur_pos}); // R1
        pwr_d = pwr_q;
        pwr_vld_d = smp_take;
        if (smp_take) begin
            // full-scale codes would set the sign bit; saturate instead
            pwr_d = (prod > PWR_POS_MAX) ? PWR_POS_MAX : prod; // R3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pwr_q <= '0;
            pwr_vld_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            pwr_vld_q <= pwr_vld_d;
        end
    end

    always_comb begin
        sum = {1'b0, en_q.acc[PWR_W-2:0]} + {1'b0, pwr_q[PWR_W-2:0]};
        en_d = en_q;
        if (pwr_vld_q) begin
            en_d.acc = {1'b0, sum[PWR_W-2:0]}; // R5
            if (sum[PWR_W-1]) begin
                en_d.roll = en_q.roll + 16'h0001; // R6 R7
            end
            en_d.cnt = en_q.cnt + 24'h00_0001; // R8
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            en_q <= '0;
        end else begin
            en_q <= en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // energy snapshot
    pepwm_energy_t snap_q;
    pepwm_energy_t snap_d;

    always_comb begin
        snap_d = snap_q;
        // first word of either energy read freezes all three counts
        if (reg_rd && (reg_addr == A_EN_SHORT0 || reg_addr == A_EN_WIDE0)) begin
            snap_d = en_q; // R22
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            snap_q <= '0;
        end else begin
            snap_q <= snap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peaks
    logic [SMP_W-1:0] pk_cur;
    logic [SMP_W-1:0] pk_vin;
    logic [SMP_W-1:0] pk_vout;
    logic [SMP_W-1:0] pk_temp;
    logic [STD_W-1:0] pk_pwr;
    logic wr_zero;

    assign wr_zero = reg_wr && (reg_wdata == '0); // R15

    // R13 R14 R23
    pepwm_peak #(.W(SMP_W)) u_pk_cur (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .upd(smp_take),
        .val(cur_pos),
        .clr(wr_zero && reg_addr == A_PK_CUR),
        .peak(pk_cur)
    );

    pepwm_peak #(.W(SMP_W)) u_pk_vin (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .upd(smp_take),
        .val(smp.vin),
        .clr(wr_zero && reg_addr == A_PK_VIN),
        .peak(pk_vin)
    );

    pepwm_peak #(.W(SMP_W)) u_pk_vout (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .upd(smp_take),
        .val(smp.vout),
        .clr(wr_zero && reg_addr == A_PK_VOUT),
        .peak(pk_vout)
    );

    pepwm_peak #(.W(SMP_W)) u_pk_temp (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .upd(smp_take),
        .val(smp.temp),
        .clr(wr_zero && reg_addr == A_PK_TEMP),
        .peak(pk_temp)
    );

    pepwm_peak #(.W(STD_W)) u_pk_pwr (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .upd(pwr_vld_q),
        .val(pwr_q[PWR_W-1:PWR_W-STD_W]),
        .clr(wr_zero && reg_addr == A_PK_PWR),
        .peak(pk_pwr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // warning limits and comparisons
    logic [LIM_W-1:0] lim_q [WARN_N];
    logic [LIM_W-1:0] lim_d [WARN_N];
    logic [WARN_N-1:0] hit;
    logic [AW-1:0] lim_idx;

    assign lim_idx = reg_addr - A_LIM_BASE;

    always_comb begin
        for (int i = 0; i < WARN_N; i++) begin
            lim_d[i] = lim_q[i];
        end
        if (reg_wr && reg_addr >= A_LIM_BASE && lim_idx < AW'(WARN_N)) begin
            lim_d[lim_idx[2:0]] = reg_wdata[LIM_W-1:0]; // R19
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < WARN_N; i++) begin
                // odd indices are the under limits, except the temperature one
                lim_q[i] <= (i % 2 == 1) ? LIM_UNDER_RST : LIM_OVER_RST; // R17
            end
            lim_q[W_OT] <= LIM_OVER_RST; // R17
        end else begin
            for (int i = 0; i < WARN_N; i++) begin
                lim_q[i] <= lim_d[i];
            end
        end
    end

    // R16 R18
    pepwm_limit_cmp #(.W(SMP_W), .OVER(1'b1)) u_vin_ov (
        .valid(smp_take), .val(smp.vin), .limit(lim_q[W_VIN_OV]), .hit(hit[W_VIN_OV])
    );
    pepwm_limit_cmp #(.W(SMP_W), .OVER(1'b0)) u_vin_uv (
        .valid(smp_take), .val(smp.vin), .limit(lim_q[W_VIN_UV]), .hit(hit[W_VIN_UV])
    );
    pepwm_limit_cmp #(.W(SMP_W), .OVER(1'b1)) u_vout_ov (
        .valid(smp_take), .val(smp.vout), .limit(lim_q[W_VOUT_OV]), .hit(hit[W_VOUT_OV])
    );
    pepwm_limit_cmp #(.W(SMP_W), .OVER(1'b0)) u_vout_uv (
        .valid(smp_take), .val(smp.vout), .limit(lim_q[W_VOUT_UV]), .hit(hit[W_VOUT_UV])
    );
    pepwm_limit_cmp #(.W(SMP_W), .OVER(1'b1)) u_oc (
        .valid(smp_take), .val(cur_pos), .limit(lim_q[W_OC]), .hit(hit[W_OC])
    );
    pepwm_limit_cmp #(.W(SMP_W), .OVER(1'b1)) u_ot (
        .valid(smp_take), .val(smp.temp), .limit(lim_q[W_OT]), .hit(hit[W_OT])
    );
    pepwm_limit_cmp #(.W(STD_W), .OVER(1'b1)) u_op (
        .valid(pwr_vld_q), .val(pwr_q[PWR_W-1:PWR_W-STD_W]), .limit(lim_q[W_OP]),
        .hit(hit[W_OP])
    );

    ////////////////////////////////////////////////////////////////////////////
    // latched warnings and control
    logic [WARN_N-1:0] warn_q;
    logic [WARN_N-1:0] warn_d;
    logic clr_flt;
    logic out_cycle;

    // output switched back on after being off
    assign out_cycle = ctrl_d[C_OUT_ON] && !ctrl_q[C_OUT_ON];
    assign clr_flt = (reg_wr && reg_addr == A_CLR_FLT) || out_cycle;

    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr && reg_addr == A_CTRL) begin
            ctrl_d = reg_wdata[1:0];
        end
        // a new hit in the clearing cycle survives
        warn_d = (clr_flt ? '0 : warn_q) | hit; // R21
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
            warn_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            warn_q <= warn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rmux;

    always_comb begin
        rmux = '0;
        case (reg_addr)
            A_PWR_STD: rmux = DATA_W'(pwr_q[PWR_W-1:PWR_W-STD_W]); // R4
            A_PWR_WIDE: rmux = DATA_W'(pwr_q); // R3
            // live counts here; the snapshot is taken this same cycle
            A_EN_SHORT0: rmux = {8'h00, en_q.roll[7:0], en_q.acc[PWR_W-1:PWR_W-STD_W]}; // R11
            A_EN_SHORT1: rmux = DATA_W'(snap_q.cnt); // R11
            A_EN_WIDE0: rmux = DATA_W'(en_q.acc); // R12
            A_EN_WIDE1: rmux = DATA_W'(snap_q.roll); // R12
            A_EN_WIDE2: rmux = DATA_W'(snap_q.cnt); // R12
            A_CUR: rmux = DATA_W'(last_q.iout);
            A_VIN: rmux = DATA_W'(last_q.vin);
            A_VOUT: rmux = DATA_W'(last_q.vout);
            A_TEMP: rmux = DATA_W'(last_q.temp);
            A_PK_CUR: rmux = DATA_W'(pk_cur);
            A_PK_VIN: rmux = DATA_W'(pk_vin);
            A_PK_VOUT: rmux = DATA_W'(pk_vout);
            A_PK_PWR: rmux = DATA_W'(pk_pwr);
            A_PK_TEMP: rmux = DATA_W'(pk_temp);
            A_WARN: rmux = DATA_W'(warn_q);
            A_CTRL: rmux = DATA_W'(ctrl_q);
            default: begin
                if (reg_addr >= A_LIM_BASE && lim_idx < AW'(WARN_N)) begin
                    rmux = DATA_W'(lim_q[lim_idx[2:0]]);
                end
            end
        endcase
        rdata_d = reg_rd ? rmux : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign warn_status = warn_q;
    assign power_wide_value = pwr_q;
endmodule
`default_nettype wire

//--- tb/pepwm_monitor_props.sv
// port checker of the power monitor
`timescale 1ns/1ps
`default_nettype none
module pepwm_monitor_props
    import pepwm_pkg::*;
#(
    parameter logic [SMP_W-1:0] CUR_ZERO_CODE = 12'h000,
    parameter int AW = ADDR_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // samples and register port
    input wire logic smp_valid,
    input wire pepwm_sample_t smp,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // status
    input wire logic [WARN_N-1:0] warn_status,
    input wire logic [PWR_W-1:0] power_wide_value
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // shadow of the control word: dropped samples must not be checked
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    logic [PWR_W-1:0] prod;
    logic clr_ev;
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr && reg_addr == AW'(A_CTRL)) begin
            ctrl_d = reg_wdata[1:0];
        end
        clr_ev = reg_wr && (reg_addr == AW'(A_CLR_FLT)
            || (reg_addr == AW'(A_CTRL) && reg_wdata[C_OUT_ON] && !ctrl_q[C_OUT_ON]));
        prod = (smp.iout <= CUR_ZERO_CODE) ? '0 : PWR_W'(smp.vin) * PWR_W'(smp.iout);
        if (prod > PWR_POS_MAX) begin
            prod = PWR_POS_MAX;
        end
    end
    always_ff @(posedge ref_clk) begin
        ctrl_q <= sys_rst ? CTRL_RST : ctrl_d;
    end
    ////////////////////////////////////////
    sequence s_rd(logic [AW-1:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_smp;
        smp_valid && ctrl_q[C_MON_EN];
    endsequence
    property p_prod;
        s_smp |=> power_wide_value == $past(prod);
    endproperty
    property p_msb;
        power_wide_value[PWR_W-1] == 1'b0;
    endproperty
    property p_std;
        s_rd(AW'(A_PWR_STD)) |=> reg_rdata == {16'h0000, $past(power_wide_value[23:8])};
    endproperty
    property p_wide;
        s_rd(AW'(A_PWR_WIDE)) |=> reg_rdata == {8'h00, $past(power_wide_value)};
    endproperty
    property p_acc;
        s_rd(AW'(A_EN_WIDE0)) |=> reg_rdata[31:23] == 9'h000;
    endproperty
    property p_roll;
        s_rd(AW'(A_EN_WIDE1)) |=> reg_rdata[31:16] == 16'h0000;
    endproperty
    property p_short;
        s_rd(AW'(A_EN_SHORT0)) |=> reg_rdata[31:24] == 8'h00;
    endproperty
    property p_hold;
        !$past(sys_rst) && |($past(warn_status) & ~warn_status) |-> $past(clr_ev);
    endproperty
    property p_cause;
        |(warn_status & ~$past(warn_status)) |-> $past(smp_valid) || $past(smp_valid, 2);
    endproperty
    property p_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_prod: assert property (p_prod) else $error("power product wrong");
    a_msb: assert property (p_msb) else $error("power top bit set");
    a_std: assert property (p_std) else $error("standard power read wrong");
    a_wide: assert property (p_wide) else $error("wide power read wrong");
    a_acc: assert property (p_acc) else $error("accumulator top bits set");
    a_roll: assert property (p_roll) else $error("rollover read too wide");
    a_short: assert property (p_short) else $error("short energy read too wide");
    a_hold: assert property (p_hold) else $error("warning dropped without clear");
    a_cause: assert property (p_cause) else $error("warning without sample");
    a_idle: assert property (p_idle) else $error("read data outside slot");
endmodule

bind pepwm_monitor pepwm_monitor_props #(.CUR_ZERO_CODE(CUR_ZERO_CODE), .AW(AW))
    u_pepwm_monitor_props (.ref_clk, .sys_rst, .smp_valid, .smp, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .warn_status, .power_wide_value);
`default_nettype wire

//--- tb/pepwm_host_model.sv
// management host model on the monitor register port
`timescale 1ns/1ps
`default_nettype none
module pepwm_host_model
    import pepwm_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register port
    output var logic [ADDR_W-1:0] reg_addr,
    output var logic [DATA_W-1:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata
);
    logic [38:0] last_e;
    logic [23:0] last_n;
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        last_e = '0;
        last_n = '0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic clr_peak(input logic [ADDR_W-1:0] a);
        wr(a, 32'h0);
    endtask
    // no time stamp in the device: the caller times its own reads
    task automatic e_delta(output logic [15:0] avg, output logic [23:0] dn);
        logic [DATA_W-1:0] w0;
        logic [DATA_W-1:0] w1;
        logic [DATA_W-1:0] w2;
        logic [38:0] e;
        rd(A_EN_WIDE0, w0);
        rd(A_EN_WIDE1, w1);
        rd(A_EN_WIDE2, w2);
        // a second rollover wrap between two reads would be lost
        e = {w1[15:0], w0[22:0]};
        dn = w2[23:0] - last_n;
        avg = 16'(((e - last_e) / 39'(dn)) >> 8);
        last_e = e;
        last_n = w2[23:0];
    endtask
endmodule
`default_nettype wire

//--- tb/pepwm_monitor_tb.sv
// self-checking bench of the power and energy monitor
`timescale 1ns/1ps
`default_nettype none
module pepwm_monitor_tb
    import pepwm_pkg::*;
;
    localparam logic [SMP_W-1:0] CZ = 12'h010;
    localparam logic [WARN_N-1:0] OV_MASK = 7'h75;
    logic ref_clk;
    logic sys_rst;
    logic smp_valid;
    pepwm_sample_t smp;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [WARN_N-1:0] warn_status;
    logic [PWR_W-1:0] power_wide_value;
    int mismatches;
    int total_checks;
    logic mon_en;
    logic [23:0] m_acc;
    logic [15:0] m_roll;
    logic [23:0] m_cnt;
    logic [15:0] av;
    logic [23:0] dn;
    logic [31:0] pk_exp [5];
    pepwm_monitor #(.CUR_ZERO_CODE(CZ)) u_pepwm_monitor (.ref_clk, .sys_rst, .smp_valid, .smp,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .warn_status, .power_wide_value);
    pepwm_host_model u_pepwm_host_model (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_pepwm_host_model.rd(a, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        u_pepwm_host_model.wr(a, d);
    endtask
    task automatic acc_upd(input logic [23:0] p);
        logic [23:0] s;
        s = m_acc + p;
        if (s[23]) begin
            m_roll = m_roll + 16'h1;
        end
        m_acc = {1'b0, s[22:0]};
        m_cnt = m_cnt + 24'h1;
    endtask
    // waits until energy has landed, two edges after the sample
    task automatic send(input logic [11:0] vi, io, vo, tp);
        logic [23:0] p;
        p = (io <= CZ) ? 24'h0 : 24'(vi) * 24'(io);
        if (p > PWR_POS_MAX) begin
            p = PWR_POS_MAX;
        end
        @(posedge ref_clk);
        smp <= {io, vi, vo, tp};
        smp_valid <= 1'b1;
        @(posedge ref_clk);
        smp_valid <= 1'b0;
        @(posedge ref_clk);
        #1;
        if (mon_en) begin
            acc_upd(p);
            chk(32'(power_wide_value), 32'(p));
        end
    endtask
    // one sample with value v on the quantity behind warning i, the rest zero; for power, v is the current and vin is 12'h100
    task automatic wsend(input int i, input logic [11:0] v);
        logic [11:0] f [4];
        f = '{default: 12'h000};
        if (i == 6) begin
            f[0] = 12'h100;
        end
        case (i)
            0, 1: f[0] = v;
            2, 3: f[2] = v;
            4, 6: f[1] = v;
            5: f[3] = v;
            default: ;
        endcase
        send(f[0], f[1], f[2], f[3]);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
    initial begin
        sys_rst = 1'b1;
        smp_valid = 1'b0;
        smp = '0;
        mismatches = 0;
        total_checks = 0;
        mon_en = 1'b1;
        m_acc = '0;
        m_roll = '0;
        m_cnt = '0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < WARN_N; i++) begin
            rchk(A_LIM_BASE + 6'(i), OV_MASK[i] ? 32'h7FFF : 32'h0);
        end
        send(12'h300, 12'h200, 12'h250, 12'h120);
        send(12'h100, 12'h300, 12'h050, 12'h200);
        pk_exp = '{32'h300, 32'h300, 32'h250, 32'h600, 32'h200};
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 5; i++) begin
                rchk(A_PK_CUR + 6'(i), pk_exp[i]);
            end
            u_pepwm_host_model.clr_peak(A_PK_PWR);
            wr(A_PK_VIN, 32'h1);
            pk_exp[3] = 32'h0;
        end
        send(12'h800, 12'h011, 12'h0, 12'h0);
        send(12'h800, 12'h008, 12'h0, 12'h0);
        rchk(A_EN_SHORT0, {8'h0, m_roll[7:0], m_acc[23:8]});
        rchk(A_EN_SHORT1, {8'h0, m_cnt});
        rchk(A_EN_WIDE0, {8'h0, m_acc});
        {av, dn} = {m_roll, m_cnt};
        send(12'h400, 12'h400, 12'h0, 12'h0);
        rchk(A_EN_WIDE1, 32'(av));
        rchk(A_EN_WIDE2, 32'(dn));
        u_pepwm_host_model.e_delta(av, dn);
        @(posedge ref_clk);
        smp <= {12'hFFF, 12'hFFF, 12'h0, 12'h0};
        smp_valid <= 1'b1;
        repeat (65536) @(posedge ref_clk);
        smp_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int k = 0; k < 65536; k++) begin
            acc_upd(24'h7F_FFFF);
        end
        u_pepwm_host_model.e_delta(av, dn);
        chk(32'(dn), 32'h1_0000);
        chk(32'(av), 32'h7FFF);
        rchk(A_EN_WIDE0, {8'h0, m_acc});
        rchk(A_EN_WIDE1, {16'h0, m_roll});
        rchk(A_EN_WIDE2, {8'h0, m_cnt});
        rchk(A_PWR_WIDE, 32'h7F_FFFF);
        wr(A_PWR_STD, 32'hFFFF);
        rchk(A_PWR_STD, 32'h7FFF);
        for (int i = 0; i < WARN_N; i++) begin
            wr(A_LIM_BASE + 6'(i), 32'h100);
            wsend(i, 12'h100);
            chk(32'(warn_status), 32'h0);
            wsend(i, OV_MASK[i] ? 12'h101 : 12'h0FF);
            chk(32'(warn_status), 32'h1 << i);
            wr(A_LIM_BASE + 6'(i), OV_MASK[i] ? 32'h7FFF : 32'h0);
            wsend(7, 12'h0);
            chk(32'(warn_status), 32'h1 << i);
            wr(A_CLR_FLT, 32'h0);
            #1;
            chk(32'(warn_status), 32'h0);
        end
        wr(A_LIM_BASE, 32'h100);
        wsend(0, 12'h200);
        chk(32'(warn_status), 32'h1);
        wr(A_LIM_BASE, 32'h7FFF);
        wr(A_CTRL, 32'h2);
        wr(A_CTRL, 32'h3);
        #1;
        chk(32'(warn_status), 32'h0);
        wr(A_CTRL, 32'h1);
        mon_en = 1'b0;
        send(12'h100, 12'h100, 12'h0, 12'h0);
        rchk(A_EN_SHORT0, {8'h0, m_roll[7:0], m_acc[23:8]});
        rchk(A_EN_SHORT1, {8'h0, m_cnt});
        wr(A_CTRL, 32'h3);
        rchk(6'h3F, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
